// ===== common/usb_uart_pkg.sv
// shared constants and types for the per-channel register bank of a four-channel usb uart bridge
// assumes a usb control endpoint delivers decoded setup packets and carries out the data stage
package usb_uart_pkg;

    localparam int NUM_CHAN = 4;
    localparam int REG_W = 16;
    localparam int ADDR_W = 8;
    localparam int PIN_W = 10;
    localparam int LEVEL_W = 12;
    localparam int ERR_W = 5;
    localparam int ERR_LSB = 3;
    localparam int CHAN_IDX_W = 2;

    // request types and codes
    localparam logic [7:0] RT_VENDOR_OUT = 8'h41;
    localparam logic [7:0] RT_VENDOR_IN = 8'hC1;
    localparam logic [7:0] RT_DEVICE_OUT = 8'h40;
    localparam logic [7:0] RT_DEVICE_IN = 8'hC0;
    localparam logic [7:0] REQ_VENDOR = 8'h00;
    localparam logic [15:0] IDX_REVISION = 16'h0260;
    localparam logic [15:0] IDX_BUS_STATUS = 16'h0262;
    localparam logic [15:0] LEN_WORD = 16'h0002;
    localparam logic [15:0] LEN_NONE = 16'h0000;

    // channel register addresses, low byte of the request index
    localparam logic [7:0] ADDR_SERIAL_PORT_ENABLE = 8'h00;
    localparam logic [7:0] ADDR_BREAK_DURATION = 8'h04;
    localparam logic [7:0] ADDR_HANDSHAKE_MODE_SELECT = 8'h06;
    localparam logic [7:0] ADDR_RESUME_CHARACTER = 8'h07;
    localparam logic [7:0] ADDR_PAUSE_CHARACTER = 8'h08;
    localparam logic [7:0] ADDR_LINE_ERROR_FLAGS = 8'h09;
    localparam logic [7:0] ADDR_DRIVER_TURNAROUND_DELAY = 8'h0B;
    localparam logic [7:0] ADDR_PIN_FUNCTION_SELECT = 8'h0C;
    localparam logic [7:0] ADDR_PIN_DIRECTION = 8'h0D;
    localparam logic [7:0] ADDR_PIN_DRIVE_HIGH = 8'h0E;
    localparam logic [7:0] ADDR_PIN_DRIVE_LOW = 8'h0F;
    localparam logic [7:0] ADDR_PIN_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_PIN_CHANGE_MASK = 8'h11;
    localparam logic [7:0] ADDR_NOTIFICATION_OPTIONS = 8'h12;

    // implemented bits of each register; all others are reserved
    localparam logic [15:0] MASK_SERIAL_PORT_ENABLE = 16'h0003;
    localparam logic [15:0] MASK_BREAK_DURATION = 16'hFFFF;
    localparam logic [15:0] MASK_HANDSHAKE_MODE_SELECT = 16'h000F;
    localparam logic [15:0] MASK_CHARACTER = 16'h00FF;
    localparam logic [15:0] MASK_LINE_ERROR_FLAGS = 16'h00F8;
    localparam logic [15:0] MASK_DRIVER_TURNAROUND_DELAY = 16'h000F;
    localparam logic [15:0] MASK_PIN_FUNCTION_SELECT = 16'h03FF;
    localparam logic [15:0] MASK_PIN = 16'h03FF;
    localparam logic [15:0] MASK_PIN_LEVEL = 16'h0FFF;
    localparam logic [15:0] MASK_PIN_CHANGE_MASK = 16'h07FF;
    localparam logic [15:0] MASK_NOTIFICATION_OPTIONS = 16'h0003;
    localparam logic [15:0] MASK_BUS_STATUS = 16'h3737;

    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        REQ_NONE,
        REQ_REG_WRITE,
        REQ_REG_READ,
        REQ_REV_READ,
        REQ_STAT_WRITE,
        REQ_STAT_READ,
        REQ_BAD
    } req_kind_t;

    typedef struct packed {
        logic [7:0] request_type;
        logic [7:0] request;
        logic [15:0] value;
        logic [15:0] index;
        logic [15:0] length;
    } setup_pkt_t;

    typedef struct packed {
        logic [1:0] port_enable;
        logic [15:0] break_duration;
        logic break_load;
        logic [3:0] handshake_mode;
        logic [7:0] resume_char;
        logic [7:0] pause_char;
        logic [3:0] turnaround_delay;
        logic [9:0] pin_function;
        logic [9:0] pin_direction;
        logic [9:0] pin_out;
        logic [10:0] pin_change_mask;
        logic [1:0] notify_opts;
    } chan_cfg_t;

endpackage

// ===== verif/usb_host_model.sv
// host side of the vendor control requests, one setup packet at a time
// assumes the bank answers on the cycle after the taking edge
`timescale 1ns/1ps

module usb_host_model (
    input wire logic mclk,
    input wire logic resp_valid,
    input wire logic resp_stall,
    input wire logic [15:0] resp_data,
    output logic setup_valid,
    output usb_uart_pkg::setup_pkt_t setup
);
    initial begin
        setup_valid = 1'b0;
        setup = '0;
    end

    // type, channel code and write order come from the caller
    task automatic xfer(input logic [7:0] rt, input logic [15:0] val, input logic [15:0] idx,
            input logic [15:0] len, output logic vld, output logic st, output logic [15:0] dat);
        @(posedge mclk);
        #1;
        setup_valid = 1'b1;
        setup = {rt, 8'h00, val, idx, len};
        @(posedge mclk);
        #1;
        setup_valid = 1'b0;
        // stale fields must not look like a held packet
        setup = ~setup;
        vld = resp_valid;
        st = resp_stall;
        dat = resp_data;
    endtask
endmodule // usb_host_model

// ===== verif/usb_uart_channel_register_bank_props.sv
// port assertions for the channel register bank
// assumes one answer on the cycle after each taken setup packet
`timescale 1ns/1ps

module usb_uart_channel_register_bank_props #(
    parameter int NUM_CHAN = 4,
    parameter logic [15:0] REVISION_VALUE = 16'h0001
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic setup_valid,
    input wire usb_uart_pkg::setup_pkt_t setup,
    input wire logic resp_valid,
    input wire logic resp_stall,
    input wire logic [15:0] resp_data,
    input wire usb_uart_pkg::chan_cfg_t chan_cfg [NUM_CHAN],
    input wire logic [15:0] bus_status
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_take(logic [7:0] rt, logic [15:0] len);
        setup_valid && setup.request_type == rt && setup.request == 8'h00 && setup.length == len;
    endsequence

    a_answer_next: assert property (setup_valid |=> resp_valid)
        else $error("no answer after a setup packet");
    a_no_stray_answer: assert property (!setup_valid |=> !resp_valid)
        else $error("answer without a setup packet");
    a_stall_with_answer: assert property (resp_stall |-> resp_valid)
        else $error("stall outside an answer");
    a_write_lands: assert property (s_take(8'h41, 16'h0000) ##0 setup.index == 16'h0000
        |=> chan_cfg[0].port_enable == $past(setup.value[1:0]))
        else $error("enable write not stored");
    a_break_load: assert property (s_take(8'h41, 16'h0000) ##0 setup.index == 16'h0004
        |=> chan_cfg[0].break_load && chan_cfg[0].break_duration == $past(setup.value))
        else $error("break duration write not loaded");
    a_write_data_zero: assert property (s_take(8'h41, 16'h0000) |=> resp_data == 16'h0000)
        else $error("write answer carries data");
    a_reserved_zero: assert property (s_take(8'hC1, 16'h0002) ##0 setup.index[7:0] != 8'h04
        |=> resp_data[15:12] == 4'h0)
        else $error("reserved read bits not zero");
    a_odd_chan_stall: assert property (setup_valid && setup.index[8]
        && setup.request_type == 8'h41 |=> resp_stall)
        else $error("odd channel code accepted");
    a_revision_read: assert property (s_take(8'hC0, 16'h0002) ##0 setup.index == 16'h0260
        |=> !resp_stall && resp_data == REVISION_VALUE)
        else $error("revision read wrong");
    a_status_write: assert property (s_take(8'h40, 16'h0000) ##0 setup.index == 16'h0262
        |=> bus_status == ($past(setup.value) & 16'h3737))
        else $error("bus status write wrong");
    a_generic_no_status: assert property (s_take(8'h41, 16'h0000) |=> $stable(bus_status))
        else $error("generic write reached bus status");
    a_status_reserved: assert property ((bus_status & 16'hC8C8) == 16'h0000)
        else $error("bus status reserved bits set");
endmodule // usb_uart_channel_register_bank_props

bind usb_uart_channel_register_bank usb_uart_channel_register_bank_props #(
    .NUM_CHAN(NUM_CHAN),
    .REVISION_VALUE(REVISION_VALUE)
) u_props (
    .mclk(mclk), .resetn(resetn), .setup_valid(setup_valid), .setup(setup),
    .resp_valid(resp_valid), .resp_stall(resp_stall), .resp_data(resp_data),
    .chan_cfg(chan_cfg), .bus_status(bus_status)
);

// ===== verif/usb_uart_channel_register_bank_tb_top.sv
// self-checking bench for the channel register bank
// assumes the host model issues every request and the bank answers next cycle
`timescale 1ns/1ps

module usb_uart_channel_register_bank_tb_top;
    // arbitrary value
    localparam logic [15:0] REV = 16'h5A5A;
    typedef struct {logic [7:0] a; logic [15:0] e;} row_t;
    typedef struct {logic [7:0] rt; logic [15:0] idx; logic [15:0] len;} bad_t;
    logic mclk;
    logic resetn;
    logic setup_valid;
    usb_uart_pkg::setup_pkt_t setup;
    logic [4:0] line_error [4];
    logic [11:0] pin_level [4];
    logic resp_valid;
    logic resp_stall;
    logic [15:0] resp_data;
    usb_uart_pkg::chan_cfg_t cfg [4];
    logic [15:0] bus_status;
    logic wwr;
    logic v;
    logic s;
    logic [15:0] d;
    int n_errors = 0;
    int compares = 0;
    // enable row last so the port is stopped while configuring
    row_t rows [15] = '{'{8'h0F, 16'h0000}, '{8'h0E, 16'h0000}, '{8'h04, 16'hFFFF},
        '{8'h06, 16'h000F}, '{8'h07, 16'h00FF}, '{8'h08, 16'h00FF}, '{8'h09, 16'h00F8},
        '{8'h0B, 16'h000F}, '{8'h0C, 16'h03FF}, '{8'h0D, 16'h03FF}, '{8'h10, 16'h0FFF},
        '{8'h11, 16'h07FF}, '{8'h12, 16'h0003}, '{8'h05, 16'h0000}, '{8'h00, 16'h0003}};
    bad_t bads [6] = '{'{8'h41, 16'h0100, 16'h0000}, '{8'hC1, 16'h0800, 16'h0002},
        '{8'h42, 16'h0000, 16'h0000}, '{8'hC1, 16'h0000, 16'h0001},
        '{8'h40, 16'h0260, 16'h0000}, '{8'hC0, 16'h0264, 16'h0002}};

    usb_uart_channel_register_bank #(.NUM_CHAN(4), .REVISION_VALUE(REV)) uut (
        .mclk(mclk), .resetn(resetn), .setup_valid(setup_valid), .setup(setup),
        .line_error(line_error), .pin_level(pin_level), .resp_valid(resp_valid),
        .resp_stall(resp_stall), .resp_data(resp_data), .chan_cfg(cfg),
        .bus_status(bus_status), .write_while_running(wwr)
    );

    usb_host_model host (
        .mclk(mclk), .resp_valid(resp_valid), .resp_stall(resp_stall),
        .resp_data(resp_data), .setup_valid(setup_valid), .setup(setup)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] ch, input logic [7:0] a, input logic [15:0] val);
        host.xfer(8'h41, val, {ch, a}, 16'h0000, v, s, d);
        chk({14'h0, v, s}, 16'h0002, "write ack");
    endtask

    task automatic rd(input logic [7:0] ch, input logic [7:0] a, input logic [15:0] exp);
        host.xfer(8'hC1, 16'h0000, {ch, a}, 16'h0002, v, s, d);
        chk({14'h0, v, s}, 16'h0002, "read ack");
        chk(d, exp, "read data");
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // about 285 cycles of traffic expected
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end

    initial begin
        resetn = 1'b0;
        for (int c = 0; c < 4; c++) begin
            line_error[c] = 5'h1F;
            pin_level[c] = 12'hFFF;
        end
        repeat (6) @(posedge mclk);
        #1;
        chk({15'h0, resp_valid}, 16'h0000, "reset answer");
        chk({14'h0, cfg[0].port_enable}, 16'h0000, "reset enable");
        resetn = 1'b1;
        $display("test reset done");
        // all-ones writes probe the reserved bits of every register
        for (int c = 0; c < 4; c++) begin
            foreach (rows[r]) begin
                wr(8'(2 * c), rows[r].a, 16'hFFFF);
                rd(8'(2 * c), rows[r].a, rows[r].e);
            end
            $display("test channel %0d done", c);
        end
        chk({6'h0, cfg[0].pin_out}, 16'h03FF, "pin set");
        wr(8'h00, 8'h0F, 16'h0001);
        chk({15'h0, wwr}, 16'h0000, "run-time write");
        chk({6'h0, cfg[0].pin_out}, 16'h03FE, "pin clear");
        wr(8'h00, 8'h06, 16'h0001);
        chk({15'h0, wwr}, 16'h0001, "misuse flag");
        wr(8'h00, 8'h00, 16'h0000);
        wr(8'h00, 8'h06, 16'h0002);
        chk({15'h0, wwr}, 16'h0000, "stopped write");
        wr(8'h00, 8'h00, 16'h0003);
        rd(8'h00, 8'h06, 16'h0002);
        $display("test run-time writes done");
        host.xfer(8'hC0, 16'h0000, 16'h0260, 16'h0002, v, s, d);
        chk(d, REV, "revision");
        host.xfer(8'h40, 16'hFFFF, 16'h0262, 16'h0000, v, s, d);
        chk(bus_status, 16'h3737, "status write");
        host.xfer(8'hC0, 16'h0000, 16'h0262, 16'h0002, v, s, d);
        chk(d, 16'h3737, "status read");
        rd(8'h00, 8'h62, 16'h0000);
        rd(8'h00, 8'h60, 16'h0000);
        $display("test dedicated requests done");
        foreach (bads[i]) begin
            host.xfer(bads[i].rt, 16'h0000, bads[i].idx, bads[i].len, v, s, d);
            chk({14'h0, v, s}, 16'h0003, "refusal");
        end
        $display("test refusals done");
        @(posedge mclk);
        #1;
        resetn = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        resetn = 1'b1;
        rd(8'h06, 8'h00, 16'h0000);
        chk(bus_status, 16'h0000, "status after reset");
        $display("test second reset done");
        complete_run();
    end
endmodule // usb_uart_channel_register_bank_tb_top

// ===== verilog/usb_request_decoder.sv
// classifies one usb setup packet into a register bank request
// assumes the packet fields are stable while setup_valid is high
`timescale 1ns/1ps

module usb_request_decoder #(
    parameter int NUM_CHAN = usb_uart_pkg::NUM_CHAN
) (
    input wire usb_uart_pkg::setup_pkt_t setup,
    output usb_uart_pkg::req_kind_t kind,
    output logic [usb_uart_pkg::CHAN_IDX_W-1:0] chan
);

    logic [7:0] chan_code;
    logic chan_ok;
    logic len_word;
    logic len_none;

    assign chan_code = setup.index[15:8];
    assign chan_ok = (chan_code[0] == 1'b0) && (chan_code < 8'(2 * NUM_CHAN));
    assign chan = chan_code[usb_uart_pkg::CHAN_IDX_W:1];
    assign len_word = (setup.length == usb_uart_pkg::LEN_WORD);
    assign len_none = (setup.length == usb_uart_pkg::LEN_NONE);

    always_comb begin
        kind = usb_uart_pkg::REQ_BAD;
        if (setup.request == usb_uart_pkg::REQ_VENDOR) begin
            case (setup.request_type)
                usb_uart_pkg::RT_VENDOR_OUT: begin
                    if (chan_ok && len_none) begin
                        kind = usb_uart_pkg::REQ_REG_WRITE;
                    end
                end
                usb_uart_pkg::RT_VENDOR_IN: begin
                    if (chan_ok && len_word) begin
                        kind = usb_uart_pkg::REQ_REG_READ;
                    end
                end
                usb_uart_pkg::RT_DEVICE_OUT: begin
                    if (setup.index == usb_uart_pkg::IDX_BUS_STATUS && len_none) begin
                        kind = usb_uart_pkg::REQ_STAT_WRITE;
                    end
                end
                usb_uart_pkg::RT_DEVICE_IN: begin
                    if (setup.index == usb_uart_pkg::IDX_REVISION && len_word) begin
                        kind = usb_uart_pkg::REQ_REV_READ;
                    end else if (setup.index == usb_uart_pkg::IDX_BUS_STATUS && len_word) begin
                        kind = usb_uart_pkg::REQ_STAT_READ;
                    end
                end
                default: begin
                    kind = usb_uart_pkg::REQ_BAD;
                end
            endcase
        end
    end

endmodule // usb_request_decoder

// ===== verilog/usb_uart_channel_register_bank.sv
// per-channel control registers of a four-channel usb uart bridge, reached by vendor requests
// assumes the control endpoint presents one setup packet per setup_valid pulse and
// returns resp_data to the host, or stalls, on the following resp_valid pulse
`timescale 1ns/1ps

// How it works
// - host writes and reads channel registers
// - revision and bus status via dedicated requests
// - every register is sixteen bits wide
// - bits zero in each register's mask reserved, read as zero
// - channel in index high byte, 0x41/0xC1
module usb_uart_channel_register_bank #(
    parameter int NUM_CHAN = usb_uart_pkg::NUM_CHAN,
    // arbitrary value
    parameter logic [15:0] REVISION_VALUE = 16'h0001
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic setup_valid,
    input wire usb_uart_pkg::setup_pkt_t setup,
    input wire logic [usb_uart_pkg::ERR_W-1:0] line_error [NUM_CHAN],
    input wire logic [usb_uart_pkg::LEVEL_W-1:0] pin_level [NUM_CHAN],
    output logic resp_valid,
    output logic resp_stall,
    output logic [usb_uart_pkg::REG_W-1:0] resp_data,
    output usb_uart_pkg::chan_cfg_t chan_cfg [NUM_CHAN],
    output logic [usb_uart_pkg::REG_W-1:0] bus_status,
    output logic write_while_running
);

    usb_uart_pkg::req_kind_t kind;
    logic [usb_uart_pkg::CHAN_IDX_W-1:0] chan;
    logic [usb_uart_pkg::ADDR_W-1:0] addr;
    logic [usb_uart_pkg::REG_W-1:0] wdata;
    logic wr_en;

    usb_uart_pkg::chan_cfg_t cfg_q [NUM_CHAN];
    usb_uart_pkg::chan_cfg_t cfg_d [NUM_CHAN];
    logic [usb_uart_pkg::REG_W-1:0] rd_word [NUM_CHAN];
    logic [NUM_CHAN-1:0] misuse;

    logic [usb_uart_pkg::REG_W-1:0] stat_q;
    logic [usb_uart_pkg::REG_W-1:0] stat_d;
    logic resp_valid_q;
    logic resp_valid_d;
    logic resp_stall_q;
    logic resp_stall_d;
    logic [usb_uart_pkg::REG_W-1:0] resp_data_q;
    logic [usb_uart_pkg::REG_W-1:0] resp_data_d;
    logic misuse_q;
    logic misuse_d;

    usb_request_decoder #(
        .NUM_CHAN(NUM_CHAN)
    ) u_decoder (
        .setup(setup),
        .kind(kind),
        .chan(chan)
    );

    assign addr = setup.index[usb_uart_pkg::ADDR_W-1:0];
    assign wdata = setup.value;
    assign wr_en = setup_valid && (kind == usb_uart_pkg::REQ_REG_WRITE);

    function automatic logic runtime_reg(input logic [7:0] a);
        runtime_reg = (a == usb_uart_pkg::ADDR_PIN_DRIVE_HIGH) ||
                      (a == usb_uart_pkg::ADDR_PIN_DRIVE_LOW) ||
                      (a == usb_uart_pkg::ADDR_BREAK_DURATION) ||
                      (a == usb_uart_pkg::ADDR_LINE_ERROR_FLAGS);
    endfunction

    // implemented bits per address
    // applied on the read path only; writes take their bits by field width
    function automatic logic [15:0] reg_mask(input logic [7:0] a);
        case (a)
            usb_uart_pkg::ADDR_SERIAL_PORT_ENABLE: begin
                reg_mask = usb_uart_pkg::MASK_SERIAL_PORT_ENABLE;
            end
            usb_uart_pkg::ADDR_BREAK_DURATION: begin
                reg_mask = usb_uart_pkg::MASK_BREAK_DURATION;
            end
            usb_uart_pkg::ADDR_HANDSHAKE_MODE_SELECT: begin
                reg_mask = usb_uart_pkg::MASK_HANDSHAKE_MODE_SELECT;
            end
            usb_uart_pkg::ADDR_RESUME_CHARACTER,
            usb_uart_pkg::ADDR_PAUSE_CHARACTER: begin
                reg_mask = usb_uart_pkg::MASK_CHARACTER;
            end
            usb_uart_pkg::ADDR_LINE_ERROR_FLAGS: begin
                reg_mask = usb_uart_pkg::MASK_LINE_ERROR_FLAGS;
            end
            usb_uart_pkg::ADDR_DRIVER_TURNAROUND_DELAY: begin
                reg_mask = usb_uart_pkg::MASK_DRIVER_TURNAROUND_DELAY;
            end
            usb_uart_pkg::ADDR_PIN_FUNCTION_SELECT: begin
                reg_mask = usb_uart_pkg::MASK_PIN_FUNCTION_SELECT;
            end
            usb_uart_pkg::ADDR_PIN_DIRECTION,
            usb_uart_pkg::ADDR_PIN_DRIVE_HIGH,
            usb_uart_pkg::ADDR_PIN_DRIVE_LOW: begin
                reg_mask = usb_uart_pkg::MASK_PIN;
            end
            usb_uart_pkg::ADDR_PIN_LEVEL: begin
                reg_mask = usb_uart_pkg::MASK_PIN_LEVEL;
            end
            usb_uart_pkg::ADDR_PIN_CHANGE_MASK: begin
                reg_mask = usb_uart_pkg::MASK_PIN_CHANGE_MASK;
            end
            usb_uart_pkg::ADDR_NOTIFICATION_OPTIONS: begin
                reg_mask = usb_uart_pkg::MASK_NOTIFICATION_OPTIONS;
            end
            default: begin
                reg_mask = usb_uart_pkg::READ_ZERO;
            end
        endcase
    endfunction

    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++) begin : g_chan
            logic hit;
            logic [15:0] wm_hs;
            assign hit = wr_en && (chan == usb_uart_pkg::CHAN_IDX_W'(c));
            assign wm_hs = wdata & usb_uart_pkg::MASK_HANDSHAKE_MODE_SELECT;

            always_comb begin
                cfg_d[c] = cfg_q[c];
                cfg_d[c].break_load = 1'b0;
                if (hit) begin
                    case (addr)
                        usb_uart_pkg::ADDR_SERIAL_PORT_ENABLE: begin
                            cfg_d[c].port_enable = wdata[1:0];
                        end
                        usb_uart_pkg::ADDR_BREAK_DURATION: begin
                            cfg_d[c].break_duration = wdata;
                            cfg_d[c].break_load = 1'b1;
                        end
                        usb_uart_pkg::ADDR_HANDSHAKE_MODE_SELECT: begin
                            cfg_d[c].handshake_mode = wm_hs[3:0];
                        end
                        usb_uart_pkg::ADDR_RESUME_CHARACTER: begin
                            cfg_d[c].resume_char = wdata[7:0];
                        end
                        usb_uart_pkg::ADDR_PAUSE_CHARACTER: begin
                            cfg_d[c].pause_char = wdata[7:0];
                        end
                        usb_uart_pkg::ADDR_DRIVER_TURNAROUND_DELAY: begin
                            cfg_d[c].turnaround_delay = wdata[3:0];
                        end
                        usb_uart_pkg::ADDR_PIN_FUNCTION_SELECT: begin
                            cfg_d[c].pin_function = wdata[9:0];
                        end
                        usb_uart_pkg::ADDR_PIN_DIRECTION: begin
                            cfg_d[c].pin_direction = wdata[9:0];
                        end
                        // set and clear act only on ones, so the other pins are untouched
                        usb_uart_pkg::ADDR_PIN_DRIVE_HIGH: begin
                            cfg_d[c].pin_out = cfg_q[c].pin_out | wdata[9:0];
                        end
                        usb_uart_pkg::ADDR_PIN_DRIVE_LOW: begin
                            cfg_d[c].pin_out = cfg_q[c].pin_out & ~wdata[9:0];
                        end
                        usb_uart_pkg::ADDR_PIN_CHANGE_MASK: begin
                            cfg_d[c].pin_change_mask = wdata[10:0];
                        end
                        usb_uart_pkg::ADDR_NOTIFICATION_OPTIONS: begin
                            cfg_d[c].notify_opts = wdata[1:0];
                        end
                        // read-only and unmapped addresses ignore writes
                        default: begin
                            cfg_d[c].break_load = 1'b0;
                        end
                    endcase
                end
            end

            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    cfg_q[c] <= '0;
                end else begin
                    cfg_q[c] <= cfg_d[c];
                end
            end

            // flag a host that skipped the disable
            assign misuse[c] = hit && (cfg_q[c].port_enable != 2'b00) && !runtime_reg(addr) &&
                               (addr != usb_uart_pkg::ADDR_SERIAL_PORT_ENABLE);

            always_comb begin
                rd_word[c] = usb_uart_pkg::READ_ZERO;
                case (addr)
                    usb_uart_pkg::ADDR_SERIAL_PORT_ENABLE: begin
                        rd_word[c] = {14'h0000, cfg_q[c].port_enable};
                    end
                    usb_uart_pkg::ADDR_BREAK_DURATION: begin
                        rd_word[c] = cfg_q[c].break_duration;
                    end
                    usb_uart_pkg::ADDR_HANDSHAKE_MODE_SELECT: begin
                        rd_word[c] = {12'h000, cfg_q[c].handshake_mode};
                    end
                    usb_uart_pkg::ADDR_RESUME_CHARACTER: begin
                        rd_word[c] = {8'h00, cfg_q[c].resume_char};
                    end
                    usb_uart_pkg::ADDR_PAUSE_CHARACTER: begin
                        rd_word[c] = {8'h00, cfg_q[c].pause_char};
                    end
                    usb_uart_pkg::ADDR_LINE_ERROR_FLAGS: begin
                        rd_word[c] = {8'h00, line_error[c], 3'h0};
                    end
                    usb_uart_pkg::ADDR_DRIVER_TURNAROUND_DELAY: begin
                        rd_word[c] = {12'h000, cfg_q[c].turnaround_delay};
                    end
                    usb_uart_pkg::ADDR_PIN_FUNCTION_SELECT: begin
                        rd_word[c] = {6'h00, cfg_q[c].pin_function};
                    end
                    usb_uart_pkg::ADDR_PIN_DIRECTION: begin
                        rd_word[c] = {6'h00, cfg_q[c].pin_direction};
                    end
                    usb_uart_pkg::ADDR_PIN_LEVEL: begin
                        rd_word[c] = {4'h0, pin_level[c]};
                    end
                    usb_uart_pkg::ADDR_PIN_CHANGE_MASK: begin
                        rd_word[c] = {5'h00, cfg_q[c].pin_change_mask};
                    end
                    usb_uart_pkg::ADDR_NOTIFICATION_OPTIONS: begin
                        rd_word[c] = {14'h0000, cfg_q[c].notify_opts};
                    end
                    // write-only set and clear read as zero
                    default: begin
                        rd_word[c] = usb_uart_pkg::READ_ZERO;
                    end
                endcase
            end

            assign chan_cfg[c] = cfg_q[c];
        end
    endgenerate

    always_comb begin
        stat_d = stat_q;
        resp_valid_d = setup_valid;
        resp_stall_d = 1'b0;
        resp_data_d = usb_uart_pkg::READ_ZERO;
        misuse_d = |misuse;
        if (setup_valid) begin
            case (kind)
                usb_uart_pkg::REQ_REG_READ: begin
                    resp_data_d = rd_word[chan] & reg_mask(addr);
                end
                usb_uart_pkg::REQ_REG_WRITE: begin
                    resp_data_d = usb_uart_pkg::READ_ZERO;
                end
                usb_uart_pkg::REQ_REV_READ: begin
                    resp_data_d = REVISION_VALUE;
                end
                usb_uart_pkg::REQ_STAT_READ: begin
                    resp_data_d = stat_q;
                end
                usb_uart_pkg::REQ_STAT_WRITE: begin
                    stat_d = wdata & usb_uart_pkg::MASK_BUS_STATUS;
                end
                default: begin
                    resp_stall_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            stat_q <= usb_uart_pkg::RST_WORD;
            resp_valid_q <= 1'b0;
            resp_stall_q <= 1'b0;
            resp_data_q <= usb_uart_pkg::RST_WORD;
            misuse_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            resp_valid_q <= resp_valid_d;
            resp_stall_q <= resp_stall_d;
            resp_data_q <= resp_data_d;
            misuse_q <= misuse_d;
        end
    end

    assign resp_valid = resp_valid_q;
    assign resp_stall = resp_stall_q;
    assign resp_data = resp_data_q;
    assign bus_status = stat_q;
    assign write_while_running = misuse_q;

endmodule // usb_uart_channel_register_bank
